/* dv/dual_port_block_ram_bench.sv */
// Purpose: self-checking bench for the dual-port block memory
// Assumes: outputs settle 3 mclk after a port clock edge
// Notes:   second instance checks hold mode and a 36/9 width mix
`timescale 1ns/1ps
module dual_port_block_ram_bench;
  import dpram_pkg::*;

  localparam logic [WORD_BITS-1:0] PRE_A = 36'h6_0f0f_c3c3;
  localparam logic [WORD_BITS-1:0] W1    = 36'h9_1234_5678;
  localparam logic [WORD_BITS-1:0] W2    = 36'h3_cafe_0042;
  localparam logic [WORD_BITS-1:0] W3    = 36'hc_0bad_f00d;
  localparam logic [WORD_BITS-1:0] W4    = 36'h5_5555_aaaa;
  localparam logic [WORD_BITS-1:0] W5    = 36'ha_0001_8000;
  localparam logic [WORD_BITS-1:0] W6    = 36'h7_7e7e_8181;
  localparam logic [WORD_BITS-1:0] WX    = 36'hx_xxxx_xxxx;
  // 36-bit reader against a 9-bit writer: only the low byte and check bit 0 overlap
  localparam logic [WORD_BITS-1:0] NC_BAD = {3'b000, 1'bx, 24'h00_0000, 8'hxx};
  localparam logic [WORD_BITS-1:0] NC_MIX = 36'h1_0000_0042;

  logic      mclk;
  logic      reset;
  logic      a_clk;
  logic      b_clk;
  port_req_s a_req;
  port_req_s b_req;
  port_rsp_s rsp_a;
  port_rsp_s rsp_b;
  port_rsp_s nc_a;
  port_rsp_s nc_b;
  int        err_total;
  int        num_checks;

  initial
  begin
    mclk = 1'b0;
  end

  always #(CLK_NS/2) mclk = ~mclk;

  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  port_user pa_u (.mclk(mclk), .clk_pin(a_clk), .req(a_req));
  port_user pb_u (.mclk(mclk), .clk_pin(b_clk), .req(b_req));

  dual_port_block_ram #(.MODE_B(READ_FIRST), .PRESET_A(PRE_A)) dut_u (
    .mclk(mclk), .reset(reset), .port_a_clk(a_clk), .port_a_req(a_req),
    .port_b_clk(b_clk), .port_b_req(b_req), .port_a_rsp(rsp_a), .port_b_rsp(rsp_b));

  dual_port_block_ram #(.WIDTH_B(9), .MODE_A(NO_CHANGE)) dut_nc (
    .mclk(mclk), .reset(reset), .port_a_clk(a_clk), .port_a_req(a_req),
    .port_b_clk(b_clk), .port_b_req(b_req), .port_a_rsp(nc_a), .port_b_rsp(nc_b));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check_rsp(input port_rsp_s got, input logic [WORD_BITS-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic a_op(input logic en, input logic we, input logic pre,
                      input logic [13:0] addr, input logic [WORD_BITS-1:0] word);
    pa_u.access(en, we, pre, addr, word);
    #1;
  endtask

  task automatic b_op(input logic en, input logic we, input logic pre,
                      input logic [13:0] addr, input logic [WORD_BITS-1:0] word);
    pb_u.access(en, we, pre, addr, word);
    #1;
  endtask

  // lag delays port b by whole mclk cycles; 0 gives the synchronous case
  task automatic both(input logic wa, input logic [WORD_BITS-1:0] da, input logic wb,
                      input logic [WORD_BITS-1:0] db, input logic [13:0] addr, input int lag);
    fork
      pa_u.access(1'b1, wa, 1'b0, addr, da);
      begin
        repeat (lag) @(posedge mclk);
        pb_u.access(1'b1, wb, 1'b0, addr, db);
      end
    join
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_total++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    err_total  = 0;
    num_checks = 0;
    reset      = 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check_rsp(rsp_a, '0);
    check_rsp(rsp_b, '0);
    $display("test reset done");

    a_op(1'b1, 1'b1, 1'b0, 14'h005, W1);
    check_rsp(rsp_a, W1);
    check_rsp(nc_a, '0);
    b_op(1'b1, 1'b0, 1'b0, 14'h005, W3);
    check_rsp(rsp_b, W1);
    b_op(1'b1, 1'b1, 1'b0, 14'h005, W2);
    check_rsp(rsp_b, W1);
    a_op(1'b1, 1'b0, 1'b0, 14'h005, W3);
    check_rsp(rsp_a, W2);
    check_rsp(nc_a, W1);
    $display("test write modes done");

    a_op(1'b0, 1'b1, 1'b0, 14'h005, W4);
    check_rsp(rsp_a, W2);
    a_op(1'b1, 1'b0, 1'b1, 14'h005, W4);
    check_rsp(rsp_a, PRE_A);
    b_op(1'b1, 1'b0, 1'b0, 14'h005, W4);
    check_rsp(rsp_b, W2);
    a_op(1'b1, 1'b1, 1'b0, 14'h3e05, W3);
    b_op(1'b1, 1'b0, 1'b0, 14'h005, W4);
    check_rsp(rsp_b, W3);
    $display("test enable preset address done");

    a_op(1'b1, 1'b1, 1'b0, 14'h007, W4);
    both(1'b0, W1, 1'b0, W1, 14'h007, 0);
    check_rsp(rsp_a, W4);
    check_rsp(rsp_b, W4);
    both(1'b1, W5, 1'b0, W1, 14'h007, 0);
    check_rsp(rsp_a, W5);
    check_rsp(rsp_b, WX);
    both(1'b0, W1, 1'b1, W6, 14'h007, 0);
    check_rsp(rsp_a, W5);
    check_rsp(rsp_b, W5);
    a_op(1'b1, 1'b0, 1'b0, 14'h007, W1);
    check_rsp(rsp_a, W6);
    both(1'b1, W1, 1'b1, ~W1, 14'h008, 0);
    a_op(1'b1, 1'b0, 1'b0, 14'h008, W2);
    check_rsp(rsp_a, WX);
    both(1'b1, W3, 1'b1, W3, 14'h009, 0);
    a_op(1'b1, 1'b0, 1'b0, 14'h009, W2);
    check_rsp(rsp_a, W3);
    $display("test synchronous collisions done");

    both(1'b1, W6, 1'b0, W1, 14'h00a, 1);
    check_rsp(rsp_a, W6);
    check_rsp(rsp_b, WX);
    b_op(1'b1, 1'b0, 1'b0, 14'h00a, W1);
    check_rsp(rsp_b, W6);
    $display("test asynchronous collision done");

    both(1'b0, W1, 1'b1, W2, 14'h000, 0);
    check_rsp(nc_a, NC_BAD);
    check_rsp(nc_b, NC_MIX);
    check_rsp(rsp_a, '0);
    check_rsp(rsp_b, '0);
    a_op(1'b1, 1'b0, 1'b0, 14'h000, W1);
    check_rsp(nc_a, NC_MIX);
    check_rsp(rsp_a, W2);
    $display("test width mix done");

    complete_run();
  end

endmodule

/* dv/port_user.sv */
// Purpose: user logic on one memory port: drives its clock pin and request pins
// Assumes: mclk at 100 MHz; port clock is high for HALF mclk cycles, rising edges of back-to-back accesses are 2*HALF+1 apart
// Notes:   port clock is still between accesses; released control pins go low, address and data pins show inverted values
`timescale 1ns/1ps
module port_user
  import dpram_pkg::*;
#(
  parameter int HALF = 8
)
(
  input  wire logic mclk,
  output logic      clk_pin,
  output port_req_s req
);

  initial
  begin
    clk_pin = 1'b0;
    req     = '0;
  end

  // ---------------------------------------------------------------
  // one access: one port clock pulse
  // ---------------------------------------------------------------
  task automatic access(input logic en, input logic we, input logic pre,
                        input logic [13:0] addr, input logic [WORD_BITS-1:0] word);
    @(posedge mclk);
    req.en                 <= en;
    req.we                 <= we;
    req.sync_output_preset <= pre;
    req.addr               <= addr;
    req.write_check_bits   <= word[35:32];
    req.write_word         <= word[31:0];
    repeat (HALF) @(posedge mclk);
    clk_pin <= 1'b1;
    repeat (HALF) @(posedge mclk);
    clk_pin <= 1'b0;
    // released pins must not keep the last value
    req.en                 <= 1'b0;
    req.we                 <= 1'b0;
    req.sync_output_preset <= 1'b0;
    req.addr               <= ~addr;
    req.write_check_bits   <= ~word[35:32];
    req.write_word         <= ~word[31:0];
  endtask

endmodule

/* rtl/dpram_pkg.sv */
// Purpose: shared types and constants for the dual-port block memory
// Assumes: one system clock mclk at 100 MHz; both port clocks are sampled pins
// Notes:   a port word is packed as {check bits, data bits}, 36 bits wide
package dpram_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int DATA_BITS  = 16384;
  localparam int CHECK_BITS = 2048;
  localparam int MAX_AW     = 14;
  localparam int MAX_DW     = 32;
  localparam int MAX_PW     = 4;
  localparam int WORD_BITS  = 36;
  localparam int CLK_NS     = 10;
  localparam int WIN_BITS   = 8;
  localparam logic [WORD_BITS-1:0] OUT_RESET_VALUE = 36'h0_0000_0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    WRITE_FIRST = 3'h1,
    READ_FIRST  = 3'h2,
    NO_CHANGE   = 3'h4
  } write_mode_e;

  typedef struct packed
  {
    logic        en;
    logic        we;
    logic        sync_output_preset;
    logic [13:0] addr;
    logic [3:0]  write_check_bits;
    logic [31:0] write_word;
  } port_req_s;

  typedef struct packed
  {
    logic [3:0]  read_check_bits;
    logic [31:0] read_word;
  } port_rsp_s;

  // ---------------------------------------------------------------
  // width helpers
  // ---------------------------------------------------------------
  function automatic int data_width(int w);
    return (w >= 9) ? (w / 9) * 8 : w;
  endfunction

  function automatic int check_width(int w);
    return (w >= 9) ? w / 9 : 0;
  endfunction

  function automatic int addr_width(int w);
    return MAX_AW - $clog2(data_width(w));
  endfunction

  function automatic logic [WORD_BITS-1:0] word_mask(int w);
    logic [WORD_BITS-1:0] m;
    m = '0;
    for (int i = 0; i < MAX_DW; i++)
      if (i < data_width(w))
        m[i] = 1'b1;
    for (int k = 0; k < MAX_PW; k++)
      if (k < check_width(w))
        m[MAX_DW+k] = 1'b1;
    return m;
  endfunction

endpackage

/* rtl/dual_port_block_ram.sv */
// Purpose: dual-port block memory, two independent ports over one shared bit array
// Assumes: port clocks and requests arrive as pins and are sampled by mclk
// Notes:   port widths 1,2,4,9,18,36; collisions drive unknowns in simulation
//
// Contract
// R1: read edge registers address, loads output
// R2: write completes on one edge
// R3: transparent mode echoes written word
// R4: read-before-write shows previous stored word
// R5: hold mode leaves output unchanged
// R6: per-port write mode, default transparent
// R7: user avoids same-cell access within window
// R8: width mismatch invalidates only overlapping bits
// R9: early read after write is invalid
// R10: spaced read returns newly written word
// R11: simultaneous same-cell reads match
// R12: simultaneous differing writes corrupt cell
// R13: read-write collision: write succeeds
// R14: reader sees old only for read-before-write
// R15: no combinational address to output path
// R16: ports independent, no arbitration
// R17: outputs hold until next access
// R18: write strobe selects read-during-write behaviour
// R19: check bits stored like data bits
// R20: widths 1,2,4,9,18,36, any mix
// R21: disabled port neither writes nor changes
// R22: preset loads value, memory untouched; code still writes memory when we is also high
// R23: address width follows port width
// R24: read with strobe low, any mode
// R25: invalid bits show as unknown
//
`timescale 1ns/1ps
module dual_port_block_ram
  import dpram_pkg::*;
#(
  parameter int                   WIDTH_A  = 36,
  parameter int                   WIDTH_B  = 36,
  parameter write_mode_e          MODE_A   = WRITE_FIRST,
  parameter write_mode_e          MODE_B   = WRITE_FIRST,
  parameter logic [WORD_BITS-1:0] PRESET_A = OUT_RESET_VALUE,
  parameter logic [WORD_BITS-1:0] PRESET_B = OUT_RESET_VALUE,
  parameter int                   C2C_NS   = 20
)
(
  input  wire logic      mclk,
  input  wire logic      reset,
  input  wire logic      port_a_clk,
  input  wire port_req_s port_a_req,
  input  wire logic      port_b_clk,
  input  wire port_req_s port_b_req,
  output port_rsp_s      port_a_rsp,
  output port_rsp_s      port_b_rsp
);

  // ---------------------------------------------------------------
  // per-port constants
  // ---------------------------------------------------------------
  // R20: any width mix
  localparam int          PW_IN [2] = '{WIDTH_A, WIDTH_B};
  localparam int          DW    [2] = '{data_width(WIDTH_A), data_width(WIDTH_B)};
  // R19: check bits per port
  localparam int          PW    [2] = '{check_width(WIDTH_A), check_width(WIDTH_B)};
  // R23: address width from width
  localparam int          AW    [2] = '{addr_width(WIDTH_A), addr_width(WIDTH_B)};
  // R6: mode per port
  localparam write_mode_e MODE  [2] = '{MODE_A, MODE_B};
  localparam logic [WORD_BITS-1:0] PRESET [2] = '{PRESET_A & word_mask(WIDTH_A),
                                                  PRESET_B & word_mask(WIDTH_B)};
  // least time, rounded up, never below one cycle
  localparam int          C2C_CYC_RAW = (C2C_NS + CLK_NS - 1) / CLK_NS;
  localparam int          C2C_CYC     = (C2C_CYC_RAW < 1) ? 1 : C2C_CYC_RAW;
  localparam logic [WIN_BITS-1:0] WIN_LOAD = WIN_BITS'(C2C_CYC - 1);
  localparam int          PSA_W       = $clog2(CHECK_BITS);

  // ---------------------------------------------------------------
  // state: recent-write windows for asynchronous collisions
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic [1:0][WIN_BITS-1:0] win;
    logic [1:0][MAX_AW-1:0]   last_dstart;
    logic [1:0][PSA_W-1:0]    last_pstart;
  } ram_state_s;

  ram_state_s st;
  ram_state_s next_st;

  // shared cell array, zero at start; no reset touches it
  logic [DATA_BITS-1:0]  data_mem  = '0;
  logic [CHECK_BITS-1:0] check_mem = '0;

  logic                 clk_pin [2];
  port_req_s            req_pin [2];
  logic                 fire    [2];
  port_req_s            req     [2];
  port_rsp_s            rsp     [2];
  int                   dstart  [2];
  int                   pstart  [2];
  logic                 writing [2];
  logic [WORD_BITS-1:0] wr_w    [2];
  logic [WORD_BITS-1:0] old_w   [2];
  logic [WORD_BITS-1:0] bad_w   [2];

  assign clk_pin[0] = port_a_clk;
  assign clk_pin[1] = port_b_clk;
  assign req_pin[0] = port_a_req;
  assign req_pin[1] = port_b_req;
  assign port_a_rsp = rsp[0];
  assign port_b_rsp = rsp[1];

  // ---------------------------------------------------------------
  // ports: capture, cell lookup, collision masks, output latch
  // ---------------------------------------------------------------
  // R16: identical independent ports
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    localparam int O = 1 - p;

    port_front u_front
    (
      .mclk    (mclk),
      .reset   (reset),
      .clk_pin (clk_pin[p]),
      .req_pin (req_pin[p]),
      .fire    (fire[p]),
      .req     (req[p])
    );

    // R23: upper address bits ignored
    assign dstart[p]  = int'(req[p].addr[AW[p]-1:0]) * DW[p];
    assign pstart[p]  = int'(req[p].addr[AW[p]-1:0]) * PW[p];
    assign writing[p] = fire[p] & req[p].we;
    assign wr_w[p]    = {req[p].write_check_bits, req[p].write_word} & word_mask(PW_IN[p]);

    always_comb
    begin
      int  pos;
      logic now_hit;
      logic win_hit;
      old_w[p] = '0;
      bad_w[p] = '0;
      pos      = 0;
      now_hit  = 1'b0;
      win_hit  = 1'b0;
      for (int i = 0; i < MAX_DW; i++)
      begin
        if (i < DW[p])
        begin
          pos         = dstart[p] + i;
          old_w[p][i] = data_mem[pos];
          // R8: only overlapping bits
          now_hit = writing[O] && pos >= dstart[O] && pos < dstart[O] + DW[O];
          win_hit = st.win[O] != '0 && pos >= int'(st.last_dstart[O])
                    && pos < int'(st.last_dstart[O]) + DW[O];
          // R14: reader sees old only under read-before-write
          // R9: read too soon after the other's write
          bad_w[p][i] = (now_hit && MODE[O] != READ_FIRST) || win_hit;
        end
      end
      for (int k = 0; k < MAX_PW; k++)
      begin
        if (k < PW[p])
        begin
          pos                = pstart[p] + k;
          old_w[p][MAX_DW+k] = check_mem[pos];
          now_hit = writing[O] && pos >= pstart[O] && pos < pstart[O] + PW[O];
          win_hit = st.win[O] != '0 && pos >= int'(st.last_pstart[O])
                    && pos < int'(st.last_pstart[O]) + PW[O];
          bad_w[p][MAX_DW+k] = (now_hit && MODE[O] != READ_FIRST) || win_hit;
        end
      end
    end

    // R13: writer's output follows its own mode
    out_latch #(
      .MODE   (MODE[p]),
      .PRESET (PRESET[p])
    ) u_latch
    (
      .mclk     (mclk),
      .reset    (reset),
      .fire     (fire[p]),
      .req      (req[p]),
      .wr_word  (wr_w[p]),
      .old_word (old_w[p]),
      .bad      (bad_w[p]),
      .rsp      (rsp[p])
    );

    // -------------------------------------------------------------
    // per-port checks
    // -------------------------------------------------------------
    // R2: first bit of the written word lands in the cell
    a_write_stores_word: assert property (@(posedge mclk) disable iff (reset) // R2
      writing[p] && !writing[O] |=> data_mem[$past(dstart[p])] == $past(wr_w[p][0]))
      else $error("written bit not stored");

    // R24: plain read returns stored cells
    a_read_returns_cell: assert property (@(posedge mclk) disable iff (reset) // R24
      fire[p] && !req[p].we && !req[p].sync_output_preset && bad_w[p] == '0
      |=> rsp[p] === port_rsp_s'($past(old_w[p])))
      else $error("read did not return stored word");

    // R14: same-cycle collision poisons reader unless writer reads first
    a_collision_marks_bad: assert property (@(posedge mclk) disable iff (reset) // R14
      fire[p] && writing[O] && MODE[O] != READ_FIRST && dstart[p] == dstart[O]
      |-> bad_w[p][0])
      else $error("collision not marked invalid");
  end

  // ---------------------------------------------------------------
  // cell array writes
  // ---------------------------------------------------------------
  // R12: simultaneous writes poison overlap bits that differ
  always_ff @(posedge mclk)
  begin
    int pos;
    int ai;
    pos = 0;
    ai  = 0;
    for (int p = 0; p < 2; p++)
    begin
      // R21: nothing written unless enabled
      if (writing[p])
      begin
        // R19: check bits stored like data
        for (int i = 0; i < MAX_DW; i++)
          if (i < DW[p])
            data_mem[dstart[p]+i] <= wr_w[p][i];
        for (int k = 0; k < MAX_PW; k++)
          if (k < PW[p])
            check_mem[pstart[p]+k] <= wr_w[p][MAX_DW+k];
      end
    end
    if (writing[0] && writing[1])
    begin
      for (int j = 0; j < MAX_DW; j++)
      begin
        if (j < DW[1])
        begin
          pos = dstart[1] + j;
          ai  = pos - dstart[0];
          if (ai >= 0 && ai < DW[0] && wr_w[0][ai] != wr_w[1][j])
            data_mem[pos] <= 1'bx;
        end
      end
      for (int j = 0; j < MAX_PW; j++)
      begin
        if (j < PW[1])
        begin
          pos = pstart[1] + j;
          ai  = pos - pstart[0];
          if (ai >= 0 && ai < PW[0] && wr_w[0][MAX_DW+ai] != wr_w[1][MAX_DW+j])
            check_mem[pos] <= 1'bx;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // recent-write windows
  // ---------------------------------------------------------------
  // R10: window closes after the spacing, later reads are clean
  always_comb
  begin
    next_st = st;
    for (int p = 0; p < 2; p++)
    begin
      if (writing[p])
      begin
        next_st.win[p]         = WIN_LOAD;
        next_st.last_dstart[p] = MAX_AW'(dstart[p]);
        next_st.last_pstart[p] = PSA_W'(pstart[p]);
      end
      else if (st.win[p] != '0)
        next_st.win[p] = st.win[p] - 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // cross-port checks
  // ---------------------------------------------------------------
  sequence s_both_read_same;
    fire[0] && fire[1] && !req[0].we && !req[1].we
    && !req[0].sync_output_preset && !req[1].sync_output_preset
    && dstart[0] == dstart[1] && bad_w[0] == '0 && bad_w[1] == '0;
  endsequence

  // R11: matching simultaneous reads
  a_sync_reads_match: assert property (@(posedge mclk) disable iff (reset) // R11
    ((WIDTH_A == WIDTH_B) and s_both_read_same) |=> rsp[0] == rsp[1])
    else $error("simultaneous reads differ");

  // R10: port a's window loads WIN_LOAD the cycle after its write
  a_window_after_write: assert property (@(posedge mclk) disable iff (reset) // R10
    writing[0] |=> st.win[0] == WIN_LOAD)
    else $error("collision window not armed");

endmodule

/* rtl/out_latch.sv */
// Purpose: output latches of one port, with the configured read-during-write behaviour
// Assumes: old_word and bad come from the memory array for the address on req
// Notes:   unknown output bits in simulation mark collision results
`timescale 1ns/1ps
module out_latch
  import dpram_pkg::*;
#(
  parameter write_mode_e           MODE   = WRITE_FIRST,
  parameter logic [WORD_BITS-1:0]  PRESET = OUT_RESET_VALUE
)
(
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 fire,
  input  wire port_req_s            req,
  input  wire logic [WORD_BITS-1:0] wr_word,
  input  wire logic [WORD_BITS-1:0] old_word,
  input  wire logic [WORD_BITS-1:0] bad,
  output port_rsp_s                 rsp
);

  typedef struct packed
  {
    logic [WORD_BITS-1:0] out;
  } latch_state_s;

  latch_state_s st;
  latch_state_s next_st;

  always_comb
  begin
    // R17: hold until next access
    next_st = st;
    if (fire)
    begin
      // R22: preset beats read and write
      if (req.sync_output_preset)
        next_st.out = PRESET;
      // R18: strobe picks write behaviour
      else if (req.we)
      begin
        unique case (MODE)
          // R3: echo the written word
          WRITE_FIRST: next_st.out = wr_word;
          // R4: show the replaced word
          READ_FIRST:  next_st.out = old_word;
          // R5: keep last read
          NO_CHANGE:   next_st.out = st.out;
        endcase
      end
      else
      begin
        // R24: plain read, R25: poisoned bits
        for (int i = 0; i < WORD_BITS; i++)
          next_st.out[i] = bad[i] ? 1'bx : old_word[i];
      end
    end
  end

  // R15: outputs only from flops
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign rsp = port_rsp_s'(st.out);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_write;
    fire && req.we && !req.sync_output_preset;
  endsequence

  a_preset_loads_value: assert property (fire && req.sync_output_preset |=> st.out == PRESET) // R22
    else $error("preset value not loaded");
  // identity compare: collision results hold unknown bits on purpose
  a_idle_keeps_output: assert property (!fire |=> st.out === $past(st.out)) // R21
    else $error("output moved without an access");
  a_write_first_echo: assert property (((MODE == WRITE_FIRST) and s_write) |=> st.out == $past(wr_word)) // R3
    else $error("transparent write did not echo input");
  a_read_first_old: assert property (((MODE == READ_FIRST) and s_write) |=> st.out == $past(old_word)) // R4
    else $error("read-before-write did not show old word");
  a_no_change_keeps: assert property (((MODE == NO_CHANGE) and s_write) |=> st.out === $past(st.out)) // R5
    else $error("hold mode output changed on write");

endmodule

/* rtl/port_front.sv */
// Purpose: samples one port's clock pin and request pins, finds the clock's rising edge
// Assumes: port clock well below mclk rate; requests meet setup/hold around the port edge
// Notes:   fire is one mclk cycle long and only while the port is enabled
`timescale 1ns/1ps
module port_front
  import dpram_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      reset,
  input  wire logic      clk_pin,
  input  wire port_req_s req_pin,
  output logic           fire,
  output port_req_s      req
);

  typedef struct packed
  {
    logic      clk_s1;
    logic      clk_s2;
    logic      clk_s3;
    port_req_s req_s1;
    port_req_s req_s2;
  } front_state_s;

  front_state_s st;
  front_state_s next_st;

  // ---------------------------------------------------------------
  // two-stage capture, edge taken between stage two and three
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st        = st;
    next_st.clk_s1 = clk_pin;
    next_st.clk_s2 = st.clk_s1;
    next_st.clk_s3 = st.clk_s2;
    next_st.req_s1 = req_pin;
    next_st.req_s2 = st.req_s1;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  // R21: enable gates edge
  assign fire = st.clk_s2 & ~st.clk_s3 & st.req_s2.en;
  assign req  = st.req_s2;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // R1: one action per edge
  a_fire_single_cycle: assert property (@(posedge mclk) disable iff (reset) fire |=> !fire) // R1
    else $error("port fired on two cycles in a row");

endmodule
